// File: mrc_pkg.sv
package mrc_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_RATE_HZ = 100000000; // system clock rate
	localparam int unsigned CLK_PERIOD_NS = 10; // system clock period
	localparam int unsigned RST_IND_LOW_US = 1000; // least low time of reset indication, 1 ms
	localparam int unsigned RST_IND_LOW_CYC = (RST_IND_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RAIL_SETTLE_US = 100; // rail settle qualification time
	localparam int unsigned RAIL_SETTLE_CYC = (RAIL_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned CNT_W = 20; // width of the hold counters
	localparam int unsigned USER_IO_W = 97; // user io line count
	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic RST_IND_RESET = 1'h0; // indication low while in reset
	localparam logic CONF_RESET = 1'h0; // not configured after reset

	// sequencer states
	typedef enum logic [2:0] {
		ST_POWER_WAIT = 3'h0,
		ST_HOLD = 3'h1,
		ST_RUN = 3'h2,
		ST_SLEEP = 3'h3
	} mrc_state_type;

	// status signals grouped toward the card
	typedef struct packed {
		logic reset_indication_n;
		logic fabric_configured_flag;
		logic processor_reset_n;
		logic fabric_reset_n;
		logic rtc_load_default;
		logic battery_dead_warning;
	} mrc_status_type;
endpackage

// File: mrc_sync.sv
`timescale 1ns/1ps
// two flop synchroniser with clock enable
module mrc_sync
	import mrc_pkg::*;
#(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	// data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q; // first stage, read only by the second
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q; // second stage
	logic [WIDTH-1:0] sync_d;

	// next values
	always_comb begin
		meta_d = clk_en ? async_in : meta_q;
		sync_d = clk_en ? meta_q : sync_q;
	end

	// registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_q <= INIT;
			sync_q <= INIT;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;
endmodule

// File: mrc_reset_config.sv
`timescale 1ns/1ps
module mrc_reset_config
	import mrc_pkg::*;
#(
	parameter int unsigned IO_W = USER_IO_W,
	parameter int unsigned HOLD_CYC = RST_IND_LOW_CYC,
	parameter int unsigned SETTLE_CYC = RAIL_SETTLE_CYC
) (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic clk_en,
	// pins from the card and board monitors
	input wire logic system_reset_request_n,
	input wire logic power_valid,
	input wire logic fabric_io_supply_rail,
	input wire logic battery_good,
	// fabric side
	input wire logic fabric_config_done,
	input wire logic sleep_request,
	input wire logic [IO_W-1:0] user_io_used,
	input wire logic [IO_W-1:0] user_io_oe_req,
	input wire logic [IO_W-1:0] user_io_out_req,
	// user io pins
	input wire logic [IO_W-1:0] user_io_lines_i,
	output logic [IO_W-1:0] user_io_lines_o,
	output logic [IO_W-1:0] user_io_lines_oe,
	output logic [IO_W-1:0] user_io_in,
	// status toward card and system
	output mrc_status_type status,
	output logic sleeping
);
	// ************************************************************
	// input synchronisation
	// ************************************************************
	localparam int unsigned NSYNC = 4;
	logic [NSYNC-1:0] pins_raw; // raw pin levels
	logic [NSYNC-1:0] pins_s; // synchronised levels
	logic req_n_s; // synchronised reset request
	logic pwr_s; // synchronised power valid
	logic rail_s; // synchronised rail good
	logic bat_s; // synchronised battery good
	logic [IO_W-1:0] io_s; // synchronised io inputs
	assign pins_raw = {system_reset_request_n, power_valid, fabric_io_supply_rail, battery_good};
	// request and monitors pass two flops before use
	mrc_sync #(.WIDTH(NSYNC), .INIT(4'h1)) u_sync_pins (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clk_en(clk_en),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);
	// user io inputs are pins as well
	mrc_sync #(.WIDTH(IO_W), .INIT('0)) u_sync_io (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.clk_en(clk_en),
		.async_in(user_io_lines_i),
		.sync_out(io_s)
	);
	// split the synchronised pins back into their roles
	assign {req_n_s, pwr_s, rail_s, bat_s} = pins_s;
	assign user_io_in = io_s;
	// ************************************************************
	// reset sequencer
	// ************************************************************
	mrc_state_type state_q; // sequencer state
	mrc_state_type state_d;
	logic [CNT_W-1:0] hold_q; // low time counter
	logic [CNT_W-1:0] hold_d;
	logic ind_q; // reset indication, high when out of reset
	logic ind_d;
	logic rtc_q; // rtc default load pulse
	logic rtc_d;
	logic warn_q; // dead battery warning
	logic warn_d;
	logic hold_done; // low time served
	assign hold_done = (hold_q >= CNT_W'(HOLD_CYC - 1));
	// next state of the sequencer
	always_comb begin
		state_d = state_q;
		hold_d = hold_q;
		ind_d = ind_q;
		rtc_d = 1'h0;
		warn_d = warn_q;
		if (clk_en) begin
			case (state_q)
				// wait for power and a released request
				ST_POWER_WAIT: begin
					ind_d = 1'h0;
					hold_d = '0;
					if (pwr_s && req_n_s) begin
						state_d = ST_HOLD;
					end
				end
				// serve the least low time
				ST_HOLD: begin
					ind_d = 1'h0;
					if (!req_n_s || !pwr_s) begin
						hold_d = '0;
					end else if (hold_done) begin
						state_d = ST_RUN;
						ind_d = 1'h1;
						rtc_d = !bat_s;
						warn_d = !bat_s;
					end else begin
						hold_d = hold_q + CNT_W'(1);
					end
				end
				// normal operation
				ST_RUN: begin
					if (!req_n_s || !pwr_s) begin
						state_d = ST_HOLD;
						ind_d = 1'h0;
						hold_d = '0;
					end else if (sleep_request) begin
						state_d = ST_SLEEP;
					end
				end
				// sleep, woken by a low request
				ST_SLEEP: begin
					if (!pwr_s) begin
						state_d = ST_POWER_WAIT;
						ind_d = 1'h0;
					end else if (!req_n_s) begin
						state_d = ST_HOLD;
						ind_d = 1'h0;
						hold_d = '0;
					end
				end
				default: begin
					state_d = ST_POWER_WAIT;
					ind_d = 1'h0;
				end
			endcase
		end
	end

	// sequencer registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_POWER_WAIT;
			hold_q <= '0;
			ind_q <= RST_IND_RESET;
			rtc_q <= 1'h0;
			warn_q <= 1'h0;
		end else begin
			state_q <= state_d;
			hold_q <= hold_d;
			ind_q <= ind_d;
			rtc_q <= rtc_d;
			warn_q <= warn_d;
		end
	end

	// ************************************************************
	// configuration status
	// ************************************************************
	logic [CNT_W-1:0] settle_q; // rail settle counter
	logic [CNT_W-1:0] settle_d;
	logic conf_q; // configured flag
	logic conf_d;
	logic running; // out of reset
	assign running = (state_q == ST_RUN) || (state_q == ST_SLEEP);
	// flag rises once loaded and rails stable long enough
	always_comb begin
		settle_d = settle_q;
		conf_d = conf_q;
		if (clk_en) begin
			if (!running || !rail_s) begin
				settle_d = '0;
			end else if (settle_q < CNT_W'(SETTLE_CYC)) begin
				settle_d = settle_q + CNT_W'(1);
			end
			conf_d = running && fabric_config_done && rail_s
				&& (settle_q >= CNT_W'(SETTLE_CYC));
		end
	end

	// configuration registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			settle_q <= '0;
			conf_q <= CONF_RESET;
		end else begin
			settle_q <= settle_d;
			conf_q <= conf_d;
		end
	end

	// ************************************************************
	// user io drive
	// ************************************************************
	logic [IO_W-1:0] oe_q; // registered enables
	logic [IO_W-1:0] oe_d;
	logic [IO_W-1:0] out_q; // registered data
	logic [IO_W-1:0] out_d;

	// drive only used lines once configured
	always_comb begin
		oe_d = oe_q;
		out_d = out_q;
		if (clk_en) begin
			oe_d = conf_d ? (user_io_used & user_io_oe_req) : '0;
			out_d = user_io_out_req;
		end
	end

	// io registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			oe_q <= '0;
			out_q <= '0;
		end else begin
			oe_q <= oe_d;
			out_q <= out_d;
		end
	end

	assign user_io_lines_oe = oe_q;
	assign user_io_lines_o = out_q;
	// status outputs: processor and fabric reset are the indication itself
	assign status = {ind_q, conf_q, ind_q, ind_q, rtc_q, warn_q};
	assign sleeping = (state_q == ST_SLEEP);
	// ************************************************************
	// assertions
	// ************************************************************
	logic [CNT_W-1:0] low_cnt_q; // cycles indication has been low
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			low_cnt_q <= '0;
		end else if (ind_q) begin
			low_cnt_q <= '0;
		end else if (clk_en && low_cnt_q != '1) begin
			low_cnt_q <= low_cnt_q + CNT_W'(1);
		end
	end
	property p_low_time;
		@(posedge clk_sys) disable iff (!rstn) $rose(ind_q) |-> $past(low_cnt_q) >= CNT_W'(HOLD_CYC - 1);
	endproperty
	a_low_time: assert property (p_low_time) else $error("indication low too short");
	property p_req_low;
		@(posedge clk_sys) disable iff (!rstn) (clk_en && !req_n_s && state_q == ST_RUN) |=> !ind_q;
	endproperty
	a_req_low: assert property (p_req_low) else $error("request did not drop indication");
	property p_both_reset;
		@(posedge clk_sys) disable iff (!rstn) (clk_en && !req_n_s)
			|=> !status.processor_reset_n && !status.fabric_reset_n;
	endproperty
	a_both_reset: assert property (p_both_reset) else $error("request left a reset high");
	property p_held_req;
		@(posedge clk_sys) disable iff (!rstn) (state_q == ST_POWER_WAIT && !req_n_s) |=> state_q == ST_POWER_WAIT;
	endproperty
	a_held_req: assert property (p_held_req) else $error("left reset with request held");
	property p_wake;
		@(posedge clk_sys) disable iff (!rstn) (clk_en && state_q == ST_SLEEP && !req_n_s && pwr_s) |=> state_q == ST_HOLD;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake from sleep");
	property p_rise_high;
		@(posedge clk_sys) disable iff (!rstn) $rose(state_q == ST_RUN) |-> ind_q;
	endproperty
	a_rise_high: assert property (p_rise_high) else $error("indication not high in run");
	property p_conf_rail;
		@(posedge clk_sys) disable iff (!rstn) (conf_q && $past(clk_en)) |-> $past(rail_s) && $past(fabric_config_done);
	endproperty
	a_conf_rail: assert property (p_conf_rail) else $error("flag without rail or load");
	property p_io_float;
		@(posedge clk_sys) disable iff (!rstn) !$past(conf_d) |-> user_io_lines_oe == '0;
	endproperty
	a_io_float: assert property (p_io_float) else $error("io driven before configuration");
	property p_unused;
		@(posedge clk_sys) disable iff (!rstn) $past(clk_en) |-> (user_io_lines_oe & ~$past(user_io_used)) == '0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused io driven");
	property p_battery;
		@(posedge clk_sys) disable iff (!rstn) $rose(state_q == ST_RUN) |-> {rtc_q, warn_q} == {2{!$past(bat_s)}};
	endproperty
	a_battery: assert property (p_battery) else $error("rtc load or warning not from cell state");
	c_run: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(state_q == ST_RUN));
	c_sleep_wake: cover property (@(posedge clk_sys) disable iff (!rstn) state_q == ST_SLEEP ##1 state_q == ST_HOLD);
	c_conf: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(conf_q));
	c_warn: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(warn_q));
endmodule

// File: mrc_card.sv
`timescale 1ns/1ps
// ************************************************************
// card side reset button, pin pulled high on the board
// ************************************************************
module mrc_card (
	// clock
	input wire logic clk_sys,
	// reset request pin toward the board
	output logic system_reset_request_n
);
	logic press_q = 1'h1; // button held before power comes up
	assign system_reset_request_n = press_q ? 1'h0 : 1'h1; // pull-up level when released
	// let go of the power-up hold after a short, bounded span
	task automatic release_hold(input int unsigned n);
		repeat (n % 40) @(posedge clk_sys);
		press_q <= 1'h0;
	endtask
	// press with contact bounce, hold, then release
	task automatic press(input int unsigned n);
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			press_q <= (i != 1);
		end
		repeat (n) @(posedge clk_sys);
		press_q <= 1'h0;
	endtask
endmodule

// File: mrc_reset_config_test.sv
`timescale 1ns/1ps
module mrc_reset_config_test;
	import mrc_pkg::*;
	// ************************************************************
	// shortened counts and bench state
	// ************************************************************
	localparam int unsigned HOLD = 8;
	localparam int unsigned SETTLE = 4;
	typedef struct packed {logic [2:0] kind; logic [USER_IO_W-1:0] val;} mrc_note_type;
	logic clk_sys = 1'h0;
	logic rstn = 1'h0;
	logic pwr = 1'h0, rail = 1'h0, bat = 1'h1, done = 1'h0, slp = 1'h0, en = 1'h1;
	logic [USER_IO_W-1:0] used = '0, oe_req = '0, out_req = '0, lin = '0, lo, loe, io_in;
	logic req_n, sleeping;
	mrc_status_type status;
	mrc_note_type notes[$];
	mrc_note_type n;
	int err_count = 0, cmp_count = 0;
	logic [31:0] rnd = 32'hd7d4; // seed for the xorshift source
	// ************************************************************
	// parts under test
	// ************************************************************
	mrc_card i_card (.clk_sys(clk_sys), .system_reset_request_n(req_n));
	mrc_reset_config #(.HOLD_CYC(HOLD), .SETTLE_CYC(SETTLE)) i_dut (.clk_sys(clk_sys), .rstn(rstn),
		.clk_en(en), .system_reset_request_n(req_n), .power_valid(pwr), .fabric_io_supply_rail(rail),
		.battery_good(bat), .fabric_config_done(done), .sleep_request(slp), .user_io_used(used),
		.user_io_oe_req(oe_req), .user_io_out_req(out_req), .user_io_lines_i(lin), .user_io_lines_o(lo),
		.user_io_lines_oe(loe), .user_io_in(io_in), .status(status), .sleeping(sleeping));
	// clock source
	initial forever #5 clk_sys = ~clk_sys;
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [USER_IO_W-1:0] rvec();
		logic [127:0] w;
		for (int i = 0; i < 4; i++) begin
			rnd = rnd ^ (rnd << 13);
			rnd = rnd ^ (rnd >> 17);
			rnd = rnd ^ (rnd << 5);
			w[i*32 +: 32] = rnd;
		end
		return w[USER_IO_W-1:0];
	endfunction
	task automatic cmp(input logic [USER_IO_W-1:0] got, input logic [USER_IO_W-1:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic note(input logic [2:0] k, input logic [USER_IO_W-1:0] v);
		notes.push_back('{k, v});
	endtask
	// wait on the indication level, counting falling edges
	task automatic wait_ind(input logic v, output int unsigned c);
		c = 0;
		while (status.reset_indication_n !== v && c < 200) begin
			@(negedge clk_sys);
			c++;
		end
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// watcher: settles every queued note against the outputs
	always @(negedge clk_sys) begin
		while (notes.size() > 0) begin
			n = notes.pop_front();
			case (n.kind)
				3'h0: cmp(USER_IO_W'(status), n.val);
				3'h1: cmp(USER_IO_W'(sleeping), n.val);
				3'h2: cmp(loe, n.val);
				3'h3: cmp(lo & loe, n.val);
				default: cmp(io_in, n.val);
			endcase
		end
	end
	// watchdog against a hang
	initial begin
		#200000;
		err_count++;
		close_out();
	end
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		int unsigned c;
		repeat (8) @(posedge clk_sys);
		rstn <= 1'h1;
		pwr <= 1'h1;
		repeat (20) @(posedge clk_sys);
		note(0, '0);
		i_card.release_hold(7);
		wait_ind(1'h1, c);
		cmp(USER_IO_W'(c >= HOLD + 2 && c <= HOLD + 4), 1);
		cmp(USER_IO_W'(status), 6'h2c);
		// user lines float while the fabric is not loaded
		@(posedge clk_sys);
		used <= rvec();
		oe_req <= rvec();
		repeat (8) @(posedge clk_sys);
		note(2, '0);
		rail <= 1'h1;
		done <= 1'h1;
		@(negedge clk_sys);
		c = 0;
		while (status.fabric_configured_flag !== 1'h1 && c < 50) begin
			@(negedge clk_sys);
			c++;
		end
		cmp(USER_IO_W'(c >= SETTLE + 2 && c <= SETTLE + 5), 1);
		cmp(USER_IO_W'(status), 6'h3c);
		// used and enabled lines drive, the rest float
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			used <= rvec();
			oe_req <= rvec();
			out_req <= rvec();
			lin <= rvec();
			repeat (2) @(posedge clk_sys);
			note(2, used & oe_req);
			note(3, used & oe_req & out_req);
			note(4, lin);
		end
		done <= 1'h0;
		repeat (3) @(posedge clk_sys);
		note(0, 6'h2c);
		note(2, '0);
		// sleep, then wake by a bouncing press with a dead cell
		slp <= 1'h1;
		@(posedge clk_sys);
		slp <= 1'h0;
		repeat (3) @(posedge clk_sys);
		note(1, 1);
		bat <= 1'h0;
		i_card.press(5);
		@(negedge clk_sys);
		cmp(USER_IO_W'(sleeping), 0);
		cmp(USER_IO_W'(status.reset_indication_n), 0);
		wait_ind(1'h1, c);
		cmp(USER_IO_W'(c >= HOLD), 1);
		cmp(USER_IO_W'(status), 6'h2f);
		@(negedge clk_sys);
		cmp(USER_IO_W'(status), 6'h2d);
		// press in run, then freeze the clock enable while the hold runs
		i_card.press(3);
		@(negedge clk_sys);
		cmp(USER_IO_W'(status.processor_reset_n | status.fabric_reset_n), 0);
		@(posedge clk_sys);
		en <= 1'h0;
		repeat (6) @(posedge clk_sys);
		en <= 1'h1;
		wait_ind(1'h1, c);
		cmp(USER_IO_W'(c >= HOLD), 1);
		cmp(USER_IO_W'(status), 6'h2f);
		// sleep, then lose power: back to waiting for power
		@(posedge clk_sys);
		slp <= 1'h1;
		@(posedge clk_sys);
		slp <= 1'h0;
		pwr <= 1'h0;
		repeat (5) @(posedge clk_sys);
		note(0, 6'h01);
		note(1, 0);
		pwr <= 1'h1;
		wait_ind(1'h1, c);
		cmp(USER_IO_W'(c >= HOLD + 2 && c <= HOLD + 4), 1);
		repeat (4) @(posedge clk_sys);
		close_out();
	end
endmodule
